// ==== pkg/dynrc_pkg.sv ====
package dynrc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  IDX_ET   = 8'h44;
  localparam logic [7:0]  IDX_HOLD = 8'h45;
  localparam logic [7:0]  IDX_AD   = 8'h46;
  localparam logic [7:0]  IDX_STAT = 8'h47;
  localparam logic [31:0] A_ET     = {22'h0, IDX_ET, 2'h0};
  localparam logic [31:0] A_HOLD   = {22'h0, IDX_HOLD, 2'h0};
  localparam logic [31:0] A_AD     = {22'h0, IDX_AD, 2'h0};
  localparam logic [31:0] A_STAT   = {22'h0, IDX_STAT, 2'h0};

  // ==========================================================
  // fields, reset values, writable masks
  localparam int         ENL_BIT  = 6;
  localparam int         ENR_BIT  = 5;
  localparam int         THR_LSB  = 2;
  localparam int         HYS_LSB  = 0;
  localparam int         HOLD_LSB = 3;
  localparam int         ATK_LSB  = 4;
  localparam int         DEC_LSB  = 0;
  localparam logic [7:0] ET_RST   = 8'h0f;
  localparam logic [7:0] HOLD_RST = 8'h38;
  localparam logic [7:0] AD_RST   = 8'h00;
  localparam logic [7:0] ET_MASK  = 8'h7f;
  localparam logic [7:0] HOLD_MASK = 8'h78;

  // ==========================================================
  // datapath and timing constants
  localparam int          SW       = 16;
  localparam int          ATT_W    = 28;
  localparam int          FRAC     = 21;
  localparam logic [27:0] ATT_MAX  = 28'h6000000;
  localparam logic [27:0] ATT_ONE  = 28'h0000001;
  localparam logic [4:0]  ATK_SH   = 5'h17;
  localparam logic [4:0]  DEC_SH   = 5'h0f;
  localparam logic [4:0]  THR_DB0  = 5'h03;
  localparam int          HOLD_W   = 18;
  localparam logic [17:0] HOLD_BASE = 18'h00020;
  localparam logic [17:0] HOLD_UNIT = 18'h08000;
  localparam logic [3:0]  HOLD_LIN = 4'ha;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef enum {PH_IDLE, PH_ATTACK, PH_HOLD, PH_DECAY} dynrc_phase_t;

  // full-scale linear magnitude for a level of -db
  function automatic logic [15:0] dynrc_lin(input logic [4:0] db);
    case (db)
      5'd3: dynrc_lin = 16'd23198;   5'd4: dynrc_lin = 16'd20675;
      5'd5: dynrc_lin = 16'd18427;   5'd6: dynrc_lin = 16'd16423;
      5'd7: dynrc_lin = 16'd14637;   5'd8: dynrc_lin = 16'd13045;
      5'd9: dynrc_lin = 16'd11627;   5'd10: dynrc_lin = 16'd10362;
      5'd11: dynrc_lin = 16'd9235;   5'd12: dynrc_lin = 16'd8231;
      5'd13: dynrc_lin = 16'd7336;   5'd14: dynrc_lin = 16'd6538;
      5'd15: dynrc_lin = 16'd5827;   5'd16: dynrc_lin = 16'd5193;
      5'd17: dynrc_lin = 16'd4629;   5'd18: dynrc_lin = 16'd4125;
      5'd19: dynrc_lin = 16'd3677;   5'd20: dynrc_lin = 16'd3277;
      5'd21: dynrc_lin = 16'd2920;   5'd22: dynrc_lin = 16'd2603;
      5'd23: dynrc_lin = 16'd2320;   5'd24: dynrc_lin = 16'd2068;
      5'd25: dynrc_lin = 16'd1843;   5'd26: dynrc_lin = 16'd1642;
      default: dynrc_lin = 16'd1464;
    endcase
  endfunction : dynrc_lin

  // hold length in word clocks, zero when disabled
  function automatic logic [17:0] dynrc_hold_len(input logic [3:0] code);
    if (code == 4'h0) begin
      dynrc_hold_len = 18'h0;
    end else if (code <= HOLD_LIN) begin
      dynrc_hold_len = HOLD_BASE << (code - 4'h1);
    end else begin
      dynrc_hold_len = 18'(HOLD_UNIT * 18'(code - HOLD_LIN));
    end
  endfunction : dynrc_hold_len

endpackage : dynrc_pkg

// ==== pkg/dynrc_chan_if.sv ====
`timescale 1ns/1ps
// one channel between gain control and gain application
interface dynrc_chan_if;
  logic                strobe;
  logic signed [15:0]  din;
  logic        [27:0]  atten;
  logic signed [15:0]  dout;
  logic                dout_valid;
  modport ctrl  (output strobe, din, atten, input dout, dout_valid);
  modport apply (input strobe, din, atten, output dout, dout_valid);
endinterface : dynrc_chan_if

// ==== rtl/dynrc_gain_apply.sv ====
`timescale 1ns/1ps
module dynrc_gain_apply (
  // clock and reset
  input wire logic     aclk,
  input wire logic     aresetn,
  // channel
  dynrc_chan_if.apply  ch
);
  import dynrc_pkg::*;

  logic        [5:0]  att_db;
  logic        [3:0]  shift;
  logic        [2:0]  sub_db;
  logic signed [16:0] mult;
  logic signed [32:0] prod;
  logic signed [15:0] out_reg;
  logic signed [15:0] out_next;
  logic               vld_reg;
  logic               vld_next;

  // ==========================================================
  // whole dB attenuation to shift plus fine multiplier
  always_comb begin
    att_db = ch.atten[FRAC+5:FRAC];
    shift  = 4'(att_db / 6'd6); // 48 dB needs a shift of 8
    sub_db = 3'(att_db % 6'd6);
    case (sub_db)
      3'h0:    mult = 17'sd32768;
      3'h1:    mult = 17'sd29205;
      3'h2:    mult = 17'sd26029;
      3'h3:    mult = 17'sd23198;
      3'h4:    mult = 17'sd20675;
      default: mult = 17'sd18427;
    endcase
    prod     = 33'(ch.din * mult) >>> (15 + shift);
    out_next = ch.strobe ? prod[15:0] : out_reg;
    vld_next = ch.strobe;
  end

  // output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 16'sh0000;
      vld_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      vld_reg <= vld_next;
    end
  end

  assign ch.dout       = out_reg;
  assign ch.dout_valid = vld_reg;

endmodule : dynrc_gain_apply

// ==== rtl/dynrc_top.sv ====
`timescale 1ns/1ps
module dynrc_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // playback samples in, one word clock per strobe
  input  wire logic        smp_valid,
  input  wire logic [15:0] smp_left,
  input  wire logic [15:0] smp_right,
  // compressed samples out
  output logic             out_valid,
  output logic [15:0]      out_left,
  output logic [15:0]      out_right
);
  import dynrc_pkg::*;

  // ==========================================================
  // register and bus state
  logic [7:0]  et_reg,     et_next;
  logic [7:0]  hold_reg,   hold_next;
  logic [7:0]  ad_reg,     ad_next;
  logic        awh_reg,    awh_next;
  logic [31:0] awa_reg,    awa_next;
  logic        wh_reg,     wh_next;
  logic [31:0] wd_reg,     wd_next;
  logic        ws_reg,     ws_next;
  logic        bv_reg,     bv_next;
  logic [1:0]  br_reg,     br_next;
  logic        rv_reg,     rv_next;
  logic [31:0] rd_reg,     rd_next;
  logic [1:0]  rr_reg,     rr_next;
  logic        aw_h;
  logic        w_h;
  logic [31:0] wa;
  logic [7:0]  wb;
  logic        wlane;

  // per-channel state
  logic [27:0]  att_reg   [2];
  logic [17:0]  hcnt_reg  [2];
  dynrc_phase_t ph_reg    [2];
  logic [15:0]  smp       [2];
  logic         ch_en     [2];

  // shared settings
  logic [3:0]  atk_code;
  logic [3:0]  dec_code;
  logic [17:0] hold_len;
  logic [15:0] thr_lin;
  logic [15:0] rel_lin;

  dynrc_chan_if ch[2] ();

  // ==========================================================
  // axi4-lite handshakes, one write and one read in flight
  assign s_axi_awready = !awh_reg && !bv_reg;
  assign s_axi_wready  = !wh_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;

  // write path: address and data in either order, then the store
  always_comb begin
    et_next   = et_reg;
    hold_next = hold_reg;
    ad_next   = ad_reg;
    awh_next  = awh_reg;
    awa_next  = awa_reg;
    wh_next   = wh_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb[0];
    end
    aw_h  = awh_next;
    w_h   = wh_next;
    wa    = awa_next;
    wb    = wd_next[7:0];
    wlane = ws_next;
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (aw_h && w_h && !bv_reg) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = RESP_OK;
      // reserved bits are held at zero whatever is written
      if (wa == A_ET) begin
        if (wlane) et_next = wb & ET_MASK;
      end else if (wa == A_HOLD) begin
        if (wlane) hold_next = wb & HOLD_MASK;
      end else if (wa == A_AD) begin
        if (wlane) ad_next = wb;
      end else if (wa == A_STAT) begin
        br_next = RESP_OK;
      end else begin
        br_next = RESP_ERR;
      end
    end
  end

  // read path
  always_comb begin
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = RESP_OK;
      if (s_axi_araddr == A_ET) begin
        rd_next = {24'h0, et_reg};
      end else if (s_axi_araddr == A_HOLD) begin
        rd_next = {24'h0, hold_reg};
      end else if (s_axi_araddr == A_AD) begin
        rd_next = {24'h0, ad_reg};
      end else if (s_axi_araddr == A_STAT) begin
        rd_next = {14'h0, ph_reg[1] == PH_ATTACK, ph_reg[0] == PH_ATTACK,
                   2'h0, att_reg[1][FRAC+5:FRAC], 2'h0, att_reg[0][FRAC+5:FRAC]};
      end else begin
        rd_next = 32'h0;
        rr_next = RESP_ERR;
      end
    end
  end

  // bus and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      et_reg   <= ET_RST;
      hold_reg <= HOLD_RST;
      ad_reg   <= AD_RST;
      awh_reg  <= 1'b0;
      awa_reg  <= 32'h0;
      wh_reg   <= 1'b0;
      wd_reg   <= 32'h0;
      ws_reg   <= 1'b0;
      bv_reg   <= 1'b0;
      br_reg   <= RESP_OK;
      rv_reg   <= 1'b0;
      rd_reg   <= 32'h0;
      rr_reg   <= RESP_OK;
    end else begin
      et_reg   <= et_next;
      hold_reg <= hold_next;
      ad_reg   <= ad_next;
      awh_reg  <= awh_next;
      awa_reg  <= awa_next;
      wh_reg   <= wh_next;
      wd_reg   <= wd_next;
      ws_reg   <= ws_next;
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      rr_reg   <= rr_next;
    end
  end

  // ==========================================================
  // settings decoded from the control registers
  always_comb begin
    atk_code = ad_reg[ATK_LSB+3:ATK_LSB];
    dec_code = ad_reg[DEC_LSB+3:DEC_LSB];
    hold_len = dynrc_hold_len(hold_reg[HOLD_LSB+3:HOLD_LSB]);
    thr_lin  = dynrc_lin(5'(THR_DB0 + 5'h3 * et_reg[THR_LSB+2:THR_LSB]));
    rel_lin  = dynrc_lin(5'(THR_DB0 + 5'h3 * et_reg[THR_LSB+2:THR_LSB]
                            + et_reg[HYS_LSB+1:HYS_LSB]));
  end

  assign smp[0]   = smp_left;
  assign smp[1]   = smp_right;
  assign ch_en[0] = et_reg[ENL_BIT];
  assign ch_en[1] = et_reg[ENR_BIT];

  // ==========================================================
  // per-channel gain control and application
  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic [16:0]  mag;
    logic         over;
    logic         under;
    logic [27:0]  atk_step;
    logic [27:0]  dec_step;
    logic [28:0]  sum;
    logic [27:0]  att_next;
    logic [17:0]  hcnt_next;
    dynrc_phase_t ph_next;

    // level check and gain step once per word clock
    always_comb begin
      mag       = smp[g][15] ? 17'(-$signed({smp[g][15], smp[g]})) : {1'b0, smp[g]};
      over      = mag > {1'b0, thr_lin};
      under     = mag < {1'b0, rel_lin};
      atk_step  = ATT_ONE << (ATK_SH - {1'b0, atk_code});
      dec_step  = ATT_ONE << (DEC_SH - {1'b0, dec_code});
      sum       = {1'b0, att_reg[g]} + {1'b0, atk_step};
      att_next  = att_reg[g];
      hcnt_next = hcnt_reg[g];
      ph_next   = ph_reg[g];
      if (!ch_en[g]) begin
        // bypass: unity gain, state cleared
        att_next  = 28'h0;
        hcnt_next = 18'h0;
        ph_next   = PH_IDLE;
      end else if (smp_valid) begin
        if (over) begin
          att_next  = (sum > {1'b0, ATT_MAX}) ? ATT_MAX : sum[27:0];
          hcnt_next = 18'h0;
          ph_next   = PH_ATTACK;
        end else if (under) begin
          case (ph_reg[g])
            PH_ATTACK: begin
              hcnt_next = hold_len;
              ph_next   = (hold_len == 18'h0) ? PH_DECAY : PH_HOLD;
            end
            PH_HOLD: begin
              hcnt_next = hcnt_reg[g] - 18'h1;
              if (hcnt_reg[g] <= 18'h1) ph_next = PH_DECAY;
            end
            PH_DECAY: begin
              if (att_reg[g] <= dec_step) begin
                att_next = 28'h0;
                ph_next  = PH_IDLE;
              end else begin
                att_next = att_reg[g] - dec_step;
              end
            end
            default: begin
              ph_next = PH_IDLE;
            end
          endcase
        end
      end
    end

    // channel state registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        att_reg[g]  <= 28'h0;
        hcnt_reg[g] <= 18'h0;
        ph_reg[g]   <= PH_IDLE;
      end else begin
        att_reg[g]  <= att_next;
        hcnt_reg[g] <= hcnt_next;
        ph_reg[g]   <= ph_next;
      end
    end

    // attenuation in force before this word's update
    assign ch[g].strobe = smp_valid;
    assign ch[g].din    = smp[g];
    assign ch[g].atten  = att_reg[g];

    dynrc_gain_apply u_apply (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ch      (ch[g])
    );
  end

  // ==========================================================
  // outputs, registered inside the gain stages
  assign out_valid = ch[0].dout_valid;
  assign out_left  = ch[0].dout;
  assign out_right = ch[1].dout;

endmodule : dynrc_top

// ==== verification/dynrc_checker.sv ====
`timescale 1ns/1ps
module dynrc_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // sample stream
  input wire logic        smp_valid,
  input wire logic [15:0] smp_left,
  input wire logic [15:0] smp_right,
  input wire logic        out_valid,
  input wire logic [15:0] out_left,
  input wire logic [15:0] out_right
);
  import dynrc_pkg::*;
  logic [31:0] wa;
  logic [31:0] ra;
  logic [7:0]  wd;
  logic [7:0]  et_sh;
  logic [7:0]  hd_sh;
  logic [7:0]  ad_sh;
  logic        we;
  // ==========================================================
  // shadow of the control registers
  // capture address and data at their handshakes
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd <= s_axi_wdata[7:0];
      we <= s_axi_wstrb[0];
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra <= s_axi_araddr;
    end
  end
  // commit at the write response, reserved bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      et_sh <= 8'h0f;
      hd_sh <= 8'h38;
      ad_sh <= 8'h00;
    end else if (s_axi_bvalid && s_axi_bready && we) begin
      case (wa)
        A_ET:    et_sh <= wd & 8'h7f;
        A_HOLD:  hd_sh <= wd & 8'h78;
        A_AD:    ad_sh <= wd;
        default: ;
      endcase
    end
  end
  // magnitude of a signed sample
  function automatic logic [16:0] mag(input logic [15:0] v);
    mag = v[15] ? {1'b0, ~v} + 17'h1 : {1'b0, v};
  endfunction : mag
  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_out_once; smp_valid ##1 !smp_valid |-> out_valid ##1 !out_valid; endproperty
  a_out_once: assert property (p_out_once) else $error("output strobe not one cycle");
  property p_byp_l; smp_valid && !et_sh[6] && !s_axi_bvalid |=> out_left == $past(smp_left); endproperty
  a_byp_l: assert property (p_byp_l) else $error("left altered while off");
  property p_byp_r; smp_valid && !et_sh[5] && !s_axi_bvalid |=> out_right == $past(smp_right); endproperty
  a_byp_r: assert property (p_byp_r) else $error("right altered while off");
  property p_et_rd; s_axi_rvalid && ra == A_ET |-> s_axi_rdata == {24'h0, et_sh}; endproperty
  a_et_rd: assert property (p_et_rd) else $error("enable and threshold readback");
  property p_hd_rd; s_axi_rvalid && ra == A_HOLD |-> s_axi_rdata == {24'h0, hd_sh}; endproperty
  a_hd_rd: assert property (p_hd_rd) else $error("hold readback");
  property p_ad_rd; s_axi_rvalid && ra == A_AD |-> s_axi_rdata == {24'h0, ad_sh}; endproperty
  a_ad_rd: assert property (p_ad_rd) else $error("attack and decay readback");
  property p_hold_out; !smp_valid |=> $stable(out_left) && $stable(out_right); endproperty
  a_hold_out: assert property (p_hold_out) else $error("output moved without a sample");
  property p_no_boost; smp_valid |=> mag(out_left) <= mag($past(smp_left)) && mag(out_right) <= mag($past(smp_right)); endproperty
  a_no_boost: assert property (p_no_boost) else $error("output above input");
endmodule : dynrc_checker

bind dynrc_top dynrc_checker u_dynrc_checker (.*);

// ==== verification/dynrc_src_model.sv ====
`timescale 1ns/1ps
module dynrc_src_model (
  // clock
  input wire logic   aclk,
  // sample stream to the compressor
  output logic        smp_valid,
  output logic [15:0] smp_left,
  output logic [15:0] smp_right
);
  // idle at start
  initial begin
    smp_valid = 1'b0;
    smp_left = 16'h0000;
    smp_right = 16'h0000;
  end
  // one word clock: single strobe, then lines no longer carry the sample
  task automatic send(input logic [15:0] l, input logic [15:0] r);
    @(posedge aclk);
    smp_valid <= 1'b1;
    smp_left <= l;
    smp_right <= r;
    @(posedge aclk);
    smp_valid <= 1'b0;
    smp_left <= ~l;
    smp_right <= ~r;
  endtask : send
endmodule : dynrc_src_model

// ==== verification/playback_dynamic_range_compressor_test.sv ====
`timescale 1ns/1ps
module playback_dynamic_range_compressor_test;
  import dynrc_pkg::*;
  // ==========================================================
  // signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        smp_valid, out_valid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [15:0] smp_left, smp_right, out_left, out_right, vb;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          n_errors = 0, total_checks = 0, cycles = 0, nh;
  // threshold levels in -3 dB steps, hysteresis release levels in -1 dB steps
  localparam logic [15:0] THR_LIN [8] = '{16'h5a9e, 16'h4027, 16'h2d6b, 16'h2027,
                                          16'h16c3, 16'h101d, 16'h0b68, 16'h0814};
  localparam logic [15:0] HYS_LIN [4] = '{16'h5a9e, 16'h50c3, 16'h47fb, 16'h4027};
  dynrc_top dut (.*);
  dynrc_src_model src (.*);
  // clock and hang guard
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================================
  // tasks
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic axi_write(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a, output logic [31:0] dd, output logic [1:0] rs);
    logic ar_ok, r_ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      dd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    axi_write(a, v, r);
    chk({30'h0, r}, {30'h0, RESP_OK}, "bresp");
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    axi_read(a, d, r);
    chk(d, e, "readback");
    chk({30'h0, r}, {30'h0, RESP_OK}, "rresp");
  endtask : rd_chk
  task automatic chk_att(input logic [5:0] el, input logic [5:0] er);
    axi_read(A_STAT, d, r);
    chk({26'h0, d[5:0]}, {26'h0, el}, "left dB");
    chk({26'h0, d[13:8]}, {26'h0, er}, "right dB");
  endtask : chk_att
  // one word, then let the output land
  task automatic word(input logic [15:0] l, input logic [15:0] rt);
    src.send(l, rt);
    @(negedge aclk);
  endtask : word
  task automatic chk_out(input logic [15:0] l, input logic [15:0] rt);
    chk({16'h0, out_left}, {16'h0, l}, "out left");
    chk({16'h0, out_right}, {16'h0, rt}, "out right");
  endtask : chk_out
  // disabling clears the gain state
  task automatic restart(input logic [7:0] et);
    wr(A_ET, et & 8'h1f);
    wr(A_ET, et);
  endtask : restart
  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_ET, 32'h0000000f);
    rd_chk(A_HOLD, 32'h00000038);
    rd_chk(A_AD, 32'h00000000);
    axi_read(A_STAT + 32'h4, d, r);
    chk({30'h0, r}, {30'h0, RESP_ERR}, "unmapped read");
    axi_write(A_STAT + 32'h4, 8'h00, r);
    chk({30'h0, r}, {30'h0, RESP_ERR}, "unmapped write");
    wr(A_ET, 8'h03);
    word(16'h7530, 16'h8ad0);
    chk_out(16'h7530, 16'h8ad0);
    wr(A_ET, 8'h43);
    word(16'h7530, 16'h7530);
    word(16'h03e8, 16'h03e8);
    chk_out(16'h0276, 16'h03e8);
    chk_att(6'h04, 6'h00);
    restart(8'h23);
    word(16'h7530, 16'h7530);
    chk_att(6'h00, 6'h04);
    for (int t = 0; t < 8; t++) begin
      restart(8'h43 | (8'(t) << 2));
      word(THR_LIN[t], 16'h0000);
      chk_att(6'h00, 6'h00);
      word(THR_LIN[t] + 16'h0001, 16'h0000);
      chk_att(6'h04, 6'h00);
    end
    for (int c = 0; c < 5; c++) begin
      wr(A_AD, 8'(c) << 4);
      restart(8'h43);
      repeat (4) word(16'h7530, 16'h0000);
      chk_att(6'(32'h10 >> c), 6'h00);
    end
    wr(A_AD, 8'h00);
    restart(8'h43);
    repeat (13) word(16'h7530, 16'h0000);
    chk_att(6'h30, 6'h00);
    word(16'h7530, 16'h7530);
    chk_out(16'h0075, 16'h7530);
    for (int i = 0; i < 6; i++) begin
      vb = (i < 4) ? HYS_LIN[i] : HYS_LIN[3];
      nh = (i < 4) ? 0 : (32 << (i - 4));
      wr(A_HOLD, (i < 4) ? 8'h00 : (8'(i - 3) << 3));
      restart(8'h40 | ((i < 4) ? 8'(i) : 8'h03));
      word(16'h7530, 16'h0000);
      repeat (2) word(vb, 16'h0000);
      repeat (nh + 1) word(vb - 16'h0001, 16'h0000);
      chk_att(6'h04, 6'h00);
      word(vb - 16'h0001, 16'h0000);
      chk_att(6'h03, 6'h00);
    end
    wr(A_HOLD, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr(A_AD, 8'(c));
      restart(8'h43);
      repeat (2) word(16'h7530, 16'h0000);
      repeat ((64 << c) + 1) word(16'h03e8, 16'h0000);
      chk_att(6'h07, 6'h00);
      word(16'h03e8, 16'h0000);
      chk_att(6'h06, 6'h00);
    end
    final_report();
  end
endmodule : playback_dynamic_range_compressor_test
